// file: sensor_regs_pkg.sv
// Constants, types and decode functions for the sensor register bank
package sensor_regs_pkg;

    // ********************************************************************
    // Register pointers
    // ********************************************************************
    localparam logic [7:0] PTR_CONFIG    = 8'h02;
    localparam logic [7:0] PTR_SERIAL_HI = 8'hFB;
    localparam logic [7:0] PTR_SERIAL_MI = 8'hFC;
    localparam logic [7:0] PTR_SERIAL_LO = 8'hFD;
    localparam logic [7:0] PTR_MAKER     = 8'hFE;
    localparam logic [7:0] PTR_PART      = 8'hFF;

    // ********************************************************************
    // Configuration word fields
    // ********************************************************************
    localparam int CFG_SWRST   = 15;
    localparam int CFG_HEATER  = 13;
    localparam int CFG_ACQ     = 12;
    localparam int CFG_BATT    = 11;
    localparam int CFG_TRES    = 10;
    localparam int CFG_HRES_HI = 9;
    localparam int CFG_HRES_LO = 8;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    // ********************************************************************
    // Serial number layout
    // ********************************************************************
    localparam int SER_HI_TOP = 39;
    localparam int SER_HI_BOT = 24;
    localparam int SER_MI_TOP = 23;
    localparam int SER_MI_BOT = 8;
    localparam int SER_LO_TOP = 7;
    localparam logic [7:0] SER_LO_PAD = 8'h00;

    // ********************************************************************
    // Identity defaults (values are arbitrary)
    // ********************************************************************
    localparam logic [39:0] SERIAL_DEFAULT = 40'h12_3456_789A;
    localparam logic [15:0] MAKER_DEFAULT  = 16'hA5C3;
    localparam logic [15:0] PART_DEFAULT   = 16'h0C01;

    // ********************************************************************
    // Resolution codes and widths
    // ********************************************************************
    localparam logic [1:0] HRES_14 = 2'h0;
    localparam logic [1:0] HRES_11 = 2'h1;
    localparam logic [1:0] HRES_8  = 2'h2;
    localparam logic [4:0] RES_14  = 5'h0E;
    localparam logic [4:0] RES_11  = 5'h0B;
    localparam logic [4:0] RES_8   = 5'h08;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_TEMP = 2'b01,
        CONV_HUM  = 2'b10
    } conv_state_t;

    function automatic logic [4:0] tempResWidth(input logic code);
        return code ? RES_11 : RES_14;
    endfunction

    function automatic logic [4:0] humResWidth(input logic [1:0] code);
        logic [4:0] w;
        unique case (code)
            HRES_11: w = RES_11;
            HRES_8:  w = RES_8;
            default: w = RES_14;
        endcase
        return w;
    endfunction

endpackage

// file: level_sync.sv
// Two-flop synchroniser for one level input
`timescale 1ns/1ps
`default_nettype none
module level_sync (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic asyncIn,
    output logic      syncOut
);

    // ********************************************************************
    // Synchroniser chain
    // ********************************************************************
    logic firstStage;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            firstStage <= 1'b0;
            syncOut    <= 1'b0;
        end else begin
            firstStage <= asyncIn;
            syncOut    <= firstStage;
        end
    end

endmodule // level_sync
`default_nettype wire

// file: sensor_config_and_id_registers.sv
// Configuration and identification register bank of the sensor
`timescale 1ns/1ps
`default_nettype none
module sensor_config_and_id_registers #(
    parameter logic [39:0] UNIT_SERIAL = sensor_regs_pkg::SERIAL_DEFAULT,
    parameter logic [15:0] MAKER_CODE  = sensor_regs_pkg::MAKER_DEFAULT,
    parameter logic [15:0] PART_CODE   = sensor_regs_pkg::PART_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  regPtr,
    input  wire logic        regWrite,
    input  wire logic [15:0] regWrData,
    input  wire logic        regRead,
    input  wire logic        supplyLow,
    input  wire logic        measTrigger,
    input  wire logic        measHumidity,
    input  wire logic        convDone,
    output logic [15:0]      regRdData,
    output logic             rdValid,
    output logic             softResetPulse,
    output logic             heaterOn,
    output logic             acqBoth,
    output logic             tempRes,
    output logic [1:0]       humRes,
    output logic [4:0]       tempResBits,
    output logic [4:0]       humResBits,
    output logic             convTemp,
    output logic             convHum
);

    // ********************************************************************
    // Supply flag synchroniser
    // ********************************************************************
    logic supplyLowSync;

    level_sync u_supply_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .asyncIn (supplyLow),
        .syncOut (supplyLowSync)
    );

    // ********************************************************************
    // Configuration register
    // ********************************************************************
    logic       cfgWrite;
    logic       swReset;
    logic       next_softResetPulse;
    logic       next_heaterOn;
    logic       next_acqBoth;
    logic       next_tempRes;
    logic [1:0] next_humRes;
    logic [4:0] next_tempResBits;
    logic [4:0] next_humResBits;

    assign cfgWrite = regWrite
        && (regPtr == sensor_regs_pkg::PTR_CONFIG);
    assign swReset  = cfgWrite && regWrData[sensor_regs_pkg::CFG_SWRST];

    always_comb begin
        next_softResetPulse = 1'b0;
        next_heaterOn       = heaterOn;
        next_acqBoth        = acqBoth;
        next_tempRes        = tempRes;
        next_humRes         = humRes;
        if (swReset) begin
            // Self-clearing reset returns fields to defaults
            next_softResetPulse = 1'b1;
            next_heaterOn = sensor_regs_pkg::CFG_RESET[
                sensor_regs_pkg::CFG_HEATER];
            next_acqBoth  = sensor_regs_pkg::CFG_RESET[
                sensor_regs_pkg::CFG_ACQ];
            next_tempRes  = sensor_regs_pkg::CFG_RESET[
                sensor_regs_pkg::CFG_TRES];
            next_humRes   = sensor_regs_pkg::CFG_RESET[
                sensor_regs_pkg::CFG_HRES_HI:sensor_regs_pkg::CFG_HRES_LO];
        end else if (cfgWrite) begin
            // Reserved and read-only bits are dropped
            next_heaterOn = regWrData[sensor_regs_pkg::CFG_HEATER];
            next_acqBoth  = regWrData[sensor_regs_pkg::CFG_ACQ];
            next_tempRes  = regWrData[sensor_regs_pkg::CFG_TRES];
            next_humRes   = regWrData[sensor_regs_pkg::CFG_HRES_HI:
                sensor_regs_pkg::CFG_HRES_LO];
        end
        next_tempResBits = sensor_regs_pkg::tempResWidth(next_tempRes);
        next_humResBits  = sensor_regs_pkg::humResWidth(next_humRes);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            softResetPulse <= 1'b0;
            heaterOn       <= sensor_regs_pkg::CFG_RESET[
                sensor_regs_pkg::CFG_HEATER];
            acqBoth        <= sensor_regs_pkg::CFG_RESET[
                sensor_regs_pkg::CFG_ACQ];
            tempRes        <= sensor_regs_pkg::CFG_RESET[
                sensor_regs_pkg::CFG_TRES];
            humRes         <= sensor_regs_pkg::CFG_RESET[
                sensor_regs_pkg::CFG_HRES_HI:sensor_regs_pkg::CFG_HRES_LO];
            tempResBits    <= sensor_regs_pkg::RES_14;
            humResBits     <= sensor_regs_pkg::RES_14;
        end else begin
            softResetPulse <= next_softResetPulse;
            heaterOn       <= next_heaterOn;
            acqBoth        <= next_acqBoth;
            tempRes        <= next_tempRes;
            humRes         <= next_humRes;
            tempResBits    <= next_tempResBits;
            humResBits     <= next_humResBits;
        end
    end

    // ********************************************************************
    // Read path
    // ********************************************************************
    logic [15:0] readWord;
    logic [15:0] next_regRdData;
    logic        next_rdValid;

    always_comb begin
        readWord = sensor_regs_pkg::ZERO_WORD;
        unique case (regPtr)
            sensor_regs_pkg::PTR_CONFIG: begin
                // Reset bit and reserved bits read zero
                readWord[sensor_regs_pkg::CFG_HEATER] = heaterOn;
                readWord[sensor_regs_pkg::CFG_ACQ]    = acqBoth;
                readWord[sensor_regs_pkg::CFG_BATT]   = supplyLowSync;
                readWord[sensor_regs_pkg::CFG_TRES]   = tempRes;
                readWord[sensor_regs_pkg::CFG_HRES_HI:
                    sensor_regs_pkg::CFG_HRES_LO]     = humRes;
            end
            sensor_regs_pkg::PTR_SERIAL_HI: begin
                readWord = UNIT_SERIAL[sensor_regs_pkg::SER_HI_TOP:
                    sensor_regs_pkg::SER_HI_BOT];
            end
            sensor_regs_pkg::PTR_SERIAL_MI: begin
                readWord = UNIT_SERIAL[sensor_regs_pkg::SER_MI_TOP:
                    sensor_regs_pkg::SER_MI_BOT];
            end
            sensor_regs_pkg::PTR_SERIAL_LO: begin
                readWord = {UNIT_SERIAL[sensor_regs_pkg::SER_LO_TOP:0],
                    sensor_regs_pkg::SER_LO_PAD};
            end
            sensor_regs_pkg::PTR_MAKER: readWord = MAKER_CODE;
            sensor_regs_pkg::PTR_PART:  readWord = PART_CODE;
            default:                    readWord = sensor_regs_pkg::ZERO_WORD;
        endcase
        next_rdValid   = regRead;
        next_regRdData = regRead ? readWord : regRdData;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regRdData <= sensor_regs_pkg::ZERO_WORD;
            rdValid   <= 1'b0;
        end else begin
            regRdData <= next_regRdData;
            rdValid   <= next_rdValid;
        end
    end

    // ********************************************************************
    // Conversion sequencer
    // ********************************************************************
    sensor_regs_pkg::conv_state_t convState;
    sensor_regs_pkg::conv_state_t next_convState;
    logic seqBoth;
    logic next_seqBoth;

    always_comb begin
        next_convState = convState;
        next_seqBoth   = seqBoth;
        unique case (convState)
            sensor_regs_pkg::CONV_IDLE: begin
                if (measTrigger) begin
                    next_seqBoth = acqBoth;
                    if (acqBoth || !measHumidity) begin
                        next_convState = sensor_regs_pkg::CONV_TEMP;
                    end else begin
                        next_convState = sensor_regs_pkg::CONV_HUM;
                    end
                end
            end
            sensor_regs_pkg::CONV_TEMP: begin
                if (convDone) begin
                    next_convState = seqBoth ? sensor_regs_pkg::CONV_HUM
                        : sensor_regs_pkg::CONV_IDLE;
                end
            end
            sensor_regs_pkg::CONV_HUM: begin
                if (convDone) begin
                    next_convState = sensor_regs_pkg::CONV_IDLE;
                end
            end
            default: next_convState = sensor_regs_pkg::CONV_IDLE;
        endcase
        if (swReset) begin
            next_convState = sensor_regs_pkg::CONV_IDLE;
            next_seqBoth   = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            convState <= sensor_regs_pkg::CONV_IDLE;
            seqBoth   <= 1'b0;
            convTemp  <= 1'b0;
            convHum   <= 1'b0;
        end else begin
            convState <= next_convState;
            seqBoth   <= next_seqBoth;
            convTemp  <= (next_convState == sensor_regs_pkg::CONV_TEMP);
            convHum   <= (next_convState == sensor_regs_pkg::CONV_HUM);
        end
    end

    // ********************************************************************
    // Assertions
    // ********************************************************************
    a_swrst_self_clear: assert property (@(posedge clk)
        disable iff (sys_rst) swReset |=> softResetPulse ##1
            (softResetPulse == $past(swReset)))
        else $error("Soft reset pulse not one cycle");

    a_swrst_defaults: assert property (@(posedge clk)
        disable iff (sys_rst) swReset |=> !heaterOn && !acqBoth && !tempRes
            && (humRes == sensor_regs_pkg::HRES_14)
            && (tempResBits == sensor_regs_pkg::RES_14))
        else $error("Soft reset left fields set");

    a_temp_res_map: assert property (@(posedge clk)
        disable iff (sys_rst) cfgWrite && !swReset |=> (tempResBits ==
            ($past(regWrData[sensor_regs_pkg::CFG_TRES])
                ? sensor_regs_pkg::RES_11 : sensor_regs_pkg::RES_14)))
        else $error("Temperature resolution wrong");

    a_hum_res_map: assert property (@(posedge clk) disable iff (sys_rst)
        cfgWrite && !swReset && (regWrData[sensor_regs_pkg::CFG_HRES_HI:
            sensor_regs_pkg::CFG_HRES_LO] == sensor_regs_pkg::HRES_8)
        |=> humResBits == sensor_regs_pkg::RES_8)
        else $error("Humidity resolution wrong");

    a_cfg_read_back: assert property (@(posedge clk)
        disable iff (sys_rst)
        regRead && (regPtr == sensor_regs_pkg::PTR_CONFIG) |=> rdValid
            && (regRdData[7:0] == sensor_regs_pkg::ZERO_WORD[7:0])
            && !regRdData[sensor_regs_pkg::CFG_SWRST]
            && (regRdData[sensor_regs_pkg::CFG_BATT] == $past(supplyLowSync)))
        else $error("Config read back wrong");

    a_serial_read: assert property (@(posedge clk) disable iff (sys_rst)
        regRead && (regPtr >= sensor_regs_pkg::PTR_SERIAL_HI)
            && (regPtr <= sensor_regs_pkg::PTR_SERIAL_LO) |=> rdValid
            && (regRdData == ($past(regPtr) == sensor_regs_pkg::PTR_SERIAL_HI
                ? UNIT_SERIAL[39:24] : $past(regPtr) ==
                sensor_regs_pkg::PTR_SERIAL_MI ? UNIT_SERIAL[23:8]
                : {UNIT_SERIAL[7:0], 8'h00})))
        else $error("Serial word read wrong");

    a_id_codes_read: assert property (@(posedge clk)
        disable iff (sys_rst) regRead && (regPtr == sensor_regs_pkg::PTR_MAKER)
        ##1 regRead && (regPtr == sensor_regs_pkg::PTR_PART)
        |-> ##1 (regRdData == PART_CODE) && ($past(regRdData) == MAKER_CODE))
        else $error("Identity code read wrong");

    a_id_write_ignored: assert property (@(posedge clk)
        disable iff (sys_rst) regWrite
            && (regPtr != sensor_regs_pkg::PTR_CONFIG) |=> $stable(heaterOn)
            && $stable(humRes) && !softResetPulse)
        else $error("Write to read-only word had effect");

    a_seq_order: assert property (@(posedge clk) disable iff (sys_rst)
        measTrigger && !convTemp && !convHum && acqBoth && !swReset
        |=> convTemp && !convHum)
        else $error("Sequence did not start with temperature");

    a_seq_hum_next: assert property (@(posedge clk)
        disable iff (sys_rst) convTemp && convDone && seqBoth && !swReset
        |=> convHum)
        else $error("Humidity did not follow temperature");

endmodule // sensor_config_and_id_registers
`default_nettype wire

// file: reg_host_model.sv
// Host model that issues register reads and writes to the sensor bank
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
    input  wire logic        clk,
    input  wire logic [15:0] regRdData,
    input  wire logic        rdValid,
    output logic [7:0]       regPtr,
    output logic             regWrite,
    output logic [15:0]      regWrData,
    output logic             regRead
);
    // ********************************************************************
    // Idle state of the host lines
    // ********************************************************************
    initial begin
        regPtr    = 8'h00;
        regWrite  = 1'b0;
        regWrData = 16'h0000;
        regRead   = 1'b0;
    end

    // ********************************************************************
    // Access tasks, driven at the falling edge
    // ********************************************************************
    task automatic write_word(input logic [7:0] ptr, input logic [15:0] data);
        @(negedge clk);
        regPtr    = ptr;
        regWrData = {data[15:8], 8'h00};
        regWrite  = 1'b1;
        @(posedge clk);
        @(negedge clk);
        regWrite  = 1'b0;
        regPtr    = ~ptr;
        regWrData = ~data;
    endtask

    task automatic read_word(input logic [7:0] ptr, output logic [15:0] data,
                             output logic valid);
        @(negedge clk);
        regPtr  = ptr;
        regRead = 1'b1;
        @(posedge clk);
        @(negedge clk);
        data    = regRdData;
        valid   = rdValid;
        regRead = 1'b0;
        regPtr  = ~ptr;
    endtask

    task automatic read_pair(input logic [7:0] ptrA, input logic [7:0] ptrB,
                             output logic [15:0] dataA,
                             output logic [15:0] dataB);
        @(negedge clk);
        regPtr  = ptrA;
        regRead = 1'b1;
        @(posedge clk);
        @(negedge clk);
        dataA   = regRdData;
        regPtr  = ptrB;
        @(posedge clk);
        @(negedge clk);
        dataB   = regRdData;
        regRead = 1'b0;
        regPtr  = ~ptrB;
    endtask
endmodule // reg_host_model
`default_nettype wire

// file: tb.sv
// Self-checking bench for the sensor register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    // Identity values below are arbitrary
    localparam logic [39:0] SER  = 40'hA1_B2C3_D4E5;
    localparam logic [15:0] MAKR = 16'h3C5A;
    localparam logic [15:0] PRT  = 16'h7E21;

    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  regPtr;
    logic        regWrite;
    logic [15:0] regWrData;
    logic        regRead;
    logic        supplyLow = 1'b0;
    logic        measTrigger = 1'b0;
    logic        measHumidity = 1'b0;
    logic        convDone = 1'b0;
    logic [15:0] regRdData;
    logic        rdValid;
    logic        softResetPulse;
    logic        heaterOn;
    logic        acqBoth;
    logic        tempRes;
    logic [1:0]  humRes;
    logic [4:0]  tempResBits;
    logic [4:0]  humResBits;
    logic        convTemp;
    logic        convHum;
    int          failures = 0;
    int          checksDone = 0;
    int          cycles = 0;
    logic [15:0] idExp [5];
    logic [15:0] w;
    logic [15:0] w2;
    logic [4:0]  tb5;
    logic [4:0]  hb5;

    always #20 clk = ~clk;

    sensor_config_and_id_registers #(
        .UNIT_SERIAL(SER), .MAKER_CODE(MAKR), .PART_CODE(PRT)
    ) dut (
        .clk(clk), .sys_rst(sys_rst), .regPtr(regPtr), .regWrite(regWrite),
        .regWrData(regWrData), .regRead(regRead), .supplyLow(supplyLow),
        .measTrigger(measTrigger), .measHumidity(measHumidity),
        .convDone(convDone), .regRdData(regRdData), .rdValid(rdValid),
        .softResetPulse(softResetPulse), .heaterOn(heaterOn),
        .acqBoth(acqBoth), .tempRes(tempRes), .humRes(humRes),
        .tempResBits(tempResBits), .humResBits(humResBits),
        .convTemp(convTemp), .convHum(convHum)
    );

    reg_host_model host (
        .clk(clk), .regRdData(regRdData), .rdValid(rdValid), .regPtr(regPtr),
        .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead)
    );

    // ********************************************************************
    // Checking, trigger/done pulse and closing tasks
    // ********************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] ptr, input logic [15:0] exp);
        logic [15:0] d;
        logic        v;
        host.read_word(ptr, d, v);
        chk({15'h0000, v}, 16'h0001);
        chk(d, exp);
    endtask

    task automatic pulse_trig();
        @(negedge clk);
        measTrigger = 1'b1;
        @(negedge clk);
        measTrigger = 1'b0;
    endtask

    task automatic pulse_done();
        @(negedge clk);
        convDone = 1'b1;
        @(negedge clk);
        convDone = 1'b0;
    endtask

    task automatic finish_test();
        $display("checks=%0d failures=%0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            finish_test();
        end
    end

    // ********************************************************************
    // Main sequence
    // ********************************************************************
    initial begin
        idExp[0] = SER[39:24];
        idExp[1] = SER[23:8];
        idExp[2] = {SER[7:0], 8'h00};
        idExp[3] = MAKR;
        idExp[4] = PRT;
        repeat (16) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        chk({7'h00, tempRes, humRes, acqBoth, heaterOn, softResetPulse,
             rdValid, convTemp, convHum}, 16'h0000);
        chk({6'h00, tempResBits, humResBits}, {6'h00, 5'h0E, 5'h0E});
        rdchk(sensor_regs_pkg::PTR_CONFIG, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            rdchk(8'hFB + 8'(i), idExp[i]);
            host.write_word(8'hFB + 8'(i), 16'hFFFF);
            rdchk(8'hFB + 8'(i), idExp[i]);
        end
        rdchk(sensor_regs_pkg::PTR_SERIAL_LO, idExp[2]);
        chk({9'h000, regRdData[6:0]}, 16'h0000);
        host.read_pair(8'hFE, 8'hFF, w, w2);
        chk(w, MAKR);
        chk(w2, PRT);
        host.write_word(8'h55, 16'h3500);
        rdchk(8'h55, 16'h0000);
        rdchk(sensor_regs_pkg::PTR_CONFIG, 16'h0000);
        for (int t = 0; t < 2; t++) begin
            for (int h = 0; h < 3; h++) begin
                w = {5'h00, t[0], h[1:0], 8'h00};
                tb5 = t[0] ? 5'h0B : 5'h0E;
                hb5 = (h == 0) ? 5'h0E : ((h == 1) ? 5'h0B : 5'h08);
                host.write_word(sensor_regs_pkg::PTR_CONFIG, w);
                chk({13'h0000, tempRes, humRes}, {13'h0000, w[10:8]});
                chk({6'h00, tempResBits, humResBits},
                    {6'h00, tb5, hb5});
                rdchk(sensor_regs_pkg::PTR_CONFIG, w);
            end
        end
        host.write_word(sensor_regs_pkg::PTR_CONFIG, 16'h1100);
        pulse_trig();
        chk({14'h0000, convTemp, convHum}, 16'h0002);
        pulse_trig();
        pulse_done();
        chk({14'h0000, convTemp, convHum}, 16'h0001);
        pulse_done();
        chk({14'h0000, convTemp, convHum}, 16'h0000);
        host.write_word(sensor_regs_pkg::PTR_CONFIG, 16'h0000);
        measHumidity = 1'b1;
        pulse_trig();
        chk({14'h0000, convTemp, convHum}, 16'h0001);
        pulse_done();
        chk({14'h0000, convTemp, convHum}, 16'h0000);
        measHumidity = 1'b0;
        pulse_trig();
        chk({14'h0000, convTemp, convHum}, 16'h0002);
        pulse_done();
        chk({14'h0000, convTemp, convHum}, 16'h0000);
        supplyLow = 1'b1;
        repeat (3) @(negedge clk);
        rdchk(sensor_regs_pkg::PTR_CONFIG, 16'h0800);
        host.write_word(sensor_regs_pkg::PTR_CONFIG, 16'h0000);
        rdchk(sensor_regs_pkg::PTR_CONFIG, 16'h0800);
        supplyLow = 1'b0;
        repeat (3) @(negedge clk);
        host.write_word(sensor_regs_pkg::PTR_CONFIG, 16'h3500);
        chk({15'h0000, heaterOn}, 16'h0001);
        host.write_word(sensor_regs_pkg::PTR_CONFIG, 16'h8000);
        chk({12'h000, softResetPulse, heaterOn, acqBoth, tempRes},
            16'h0008);
        rdchk(sensor_regs_pkg::PTR_CONFIG, 16'h0000);
        chk({15'h0000, softResetPulse}, 16'h0000);
        finish_test();
    end
endmodule // tb
`default_nettype wire
